// ---- pkg/comparator_cfg.svh ----
// Offsets, field positions, reset values and response codes for the comparator control block.
// Assumes a 32-bit AXI4-Lite byte address space with one aligned word per register.
`ifndef COMPARATOR_CFG_SVH
`define COMPARATOR_CFG_SVH

// ============================================================
// Register byte addresses
`define CMP_CTRL_ADDR 32'hffff0444
`define CMP_MASK_ADDR 32'hffff0448
`define CMP_STAT_ADDR 32'hffff044c

// ============================================================
// Reset values
`define CMP_CTRL_RESET 9'h000
`define CMP_MASK_RESET 2'h0

// ============================================================
// Control register fields
`define CMP_EN_BIT 10
`define CMP_NEG_MSB 9
`define CMP_NEG_LSB 8
`define CMP_ROUTE_MSB 7
`define CMP_ROUTE_LSB 6
`define CMP_POL_BIT 5
`define CMP_RESP_MSB 4
`define CMP_RESP_LSB 3
`define CMP_HYST_BIT 2
`define CMP_RISE_BIT 1
`define CMP_FALL_BIT 0
`define CMP_REG_MSB 15

// ============================================================
// Output route codes
`define CMP_ROUTE_PIN 2'h2
`define CMP_ROUTE_IRQ 2'h3

// ============================================================
// Status register fields
`define CMP_STAT_RAW_BIT 0
`define CMP_STAT_RESULT_BIT 1

// ============================================================
// AXI responses
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// ---- pkg/comparator_pkg.sv ----
// Types shared by the comparator control block and its helper modules.
// Assumes comparator_cfg.svh is on the include path.
`default_nettype none
`include "comparator_cfg.svh"

package comparator_pkg;

	// ============================================================
	// Bus types
	typedef logic [31:0] axi_addr_t;
	typedef logic [31:0] axi_data_t;
	typedef logic [3:0] axi_strb_t;
	typedef logic [1:0] axi_resp_t;

	// ============================================================
	// Module state
	typedef struct packed {
		logic stage1;
		logic stage2;
	} sync_state_t;

	typedef struct packed {
		logic flag;
	} flag_state_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic arready;
		logic aw_held;
		logic w_held;
		axi_addr_t awaddr;
		axi_data_t wdata;
		axi_strb_t wstrb;
		logic bvalid;
		axi_resp_t bresp;
		logic rvalid;
		axi_data_t rdata;
		axi_resp_t rresp;
		logic [`CMP_EN_BIT:`CMP_HYST_BIT] cfg;
		logic [1:0] mask;
		logic prev_result;
		logic pin;
		logic logic_array;
		logic trig;
		logic irq;
	} ctrl_state_t;

endpackage : comparator_pkg
`default_nettype wire

// ---- design/sync2.sv ----
// Two-flop synchroniser for a single asynchronous level.
// Assumes the input toggles no faster than a few system clocks.
`timescale 1ns/1ps
`default_nettype none

module sync2 (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic async_in,
	output logic sync_out
);
	import comparator_pkg::*;

	sync_state_t s;
	sync_state_t next_s;

	// The first stage is read only by the second stage
	always_comb begin
		next_s.stage1 = async_in;
		next_s.stage2 = s.stage1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sync_out = s.stage2;

endmodule : sync2
`default_nettype wire

// ---- design/edge_flag.sv ----
// Sticky event flag, set by hardware and cleared by software.
// Assumes set and clear are single-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none

module edge_flag (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic set,
	input wire logic clear,
	output logic flag
);
	import comparator_pkg::*;

	flag_state_t s;
	flag_state_t next_s;

	// Set wins so an edge arriving with the clear is not lost
	always_comb begin
		next_s.flag = set | (s.flag & ~clear);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign flag = s.flag;

endmodule : edge_flag
`default_nettype wire

// ---- design/voltage_comparator_control.sv ----
// Control and status logic for an on-chip voltage comparator, with an AXI4-Lite slave.
// Assumes the analog core reports "positive input above negative input" on comparator_raw,
// asynchronously, and honours the enable, input select, response and hysteresis outputs.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "comparator_cfg.svh"

module voltage_comparator_control (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire comparator_pkg::axi_addr_t s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire comparator_pkg::axi_data_t s_axi_wdata,
	input wire comparator_pkg::axi_strb_t s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output comparator_pkg::axi_resp_t s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire comparator_pkg::axi_addr_t s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output comparator_pkg::axi_data_t s_axi_rdata,
	output comparator_pkg::axi_resp_t s_axi_rresp,
	input wire logic comparator_raw,
	output logic comparator_enable,
	output logic positive_input_share,
	output logic [1:0] negative_input_select,
	output logic [1:0] response_time_select,
	output logic hysteresis_enable,
	output logic comparator_output_pin,
	output logic programmable_logic_array,
	output logic adc_trigger,
	output logic irq
);
	import comparator_pkg::*;

	ctrl_state_t s;
	ctrl_state_t next_s;
	logic raw_sync;
	logic monitored;
	logic rise;
	logic fall;
	logic commit;
	logic wr_ctrl;
	logic wr_mask;
	logic clr_rise;
	logic clr_fall;
	logic rising_edge_flag;
	logic falling_edge_flag;
	logic [1:0] flags;
	logic [15:0] ctrl_view;
	axi_data_t rd_value;
	axi_resp_t rd_resp;

	// ============================================================
	// Comparator result path
	sync2 u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(comparator_raw),
		.sync_out(raw_sync)
	);

	// Result is held low while disabled so power-up cannot fake an edge
	assign monitored = s.cfg[`CMP_EN_BIT] & (raw_sync ^ s.cfg[`CMP_POL_BIT]);
	assign rise = monitored & ~s.prev_result;
	assign fall = ~monitored & s.prev_result;

	edge_flag u_rise_flag (
		.aclk(aclk),
		.aresetn(aresetn),
		.set(rise),
		.clear(clr_rise),
		.flag(rising_edge_flag)
	);

	edge_flag u_fall_flag (
		.aclk(aclk),
		.aresetn(aresetn),
		.set(fall),
		.clear(clr_fall),
		.flag(falling_edge_flag)
	);

	assign flags = {rising_edge_flag, falling_edge_flag};

	// ============================================================
	// Register decode
	assign commit = s.aw_held & s.w_held & ~s.bvalid;
	assign wr_ctrl = commit & (s.awaddr == `CMP_CTRL_ADDR);
	assign wr_mask = commit & (s.awaddr == `CMP_MASK_ADDR);
	assign clr_rise = wr_ctrl & s.wstrb[0] & s.wdata[`CMP_RISE_BIT];
	assign clr_fall = wr_ctrl & s.wstrb[0] & s.wdata[`CMP_FALL_BIT];

	// Reserved bits 15:11 read zero
	assign ctrl_view = {5'h00, s.cfg, flags};

	always_comb begin
		rd_value = '0;
		rd_resp = `AXI_RESP_OKAY;
		unique case (s_axi_araddr)
			`CMP_CTRL_ADDR: rd_value[`CMP_REG_MSB:0] = ctrl_view;
			`CMP_MASK_ADDR: rd_value[1:0] = s.mask;
			`CMP_STAT_ADDR: begin
				rd_value[`CMP_STAT_RAW_BIT] = raw_sync;
				rd_value[`CMP_STAT_RESULT_BIT] = monitored;
			end
			default: rd_resp = `AXI_RESP_SLVERR;
		endcase
	end

	// ============================================================
	// Next state
	always_comb begin
		next_s = s;
		// Write address and data are taken independently, in either order
		if (s_axi_awvalid && s.awready) begin
			next_s.aw_held = 1'b1;
			next_s.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready) begin
			next_s.w_held = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end
		if (commit) begin
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = `AXI_RESP_OKAY;
			if (wr_ctrl) begin
				if (s.wstrb[0]) begin
					next_s.cfg[`CMP_ROUTE_MSB:`CMP_HYST_BIT] =
						s.wdata[`CMP_ROUTE_MSB:`CMP_HYST_BIT];
				end
				if (s.wstrb[1]) begin
					next_s.cfg[`CMP_EN_BIT:`CMP_NEG_LSB] =
						s.wdata[`CMP_EN_BIT:`CMP_NEG_LSB];
				end
			end else if (wr_mask) begin
				if (s.wstrb[0]) begin
					next_s.mask = s.wdata[1:0];
				end
			end else if (s.awaddr != `CMP_STAT_ADDR) begin
				next_s.bresp = `AXI_RESP_SLVERR;
			end
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		next_s.awready = ~next_s.aw_held & ~next_s.bvalid;
		next_s.wready = ~next_s.w_held & ~next_s.bvalid;
		// Read: one outstanding, answered the cycle after the address is taken
		if (s_axi_arvalid && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = rd_value;
			next_s.rresp = rd_resp;
		end else if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		next_s.arready = ~next_s.rvalid;
		// Comparator outputs, registered so the ports come straight from flops
		next_s.prev_result = monitored;
		next_s.pin = (s.cfg[`CMP_ROUTE_MSB:`CMP_ROUTE_LSB] == `CMP_ROUTE_PIN) & monitored;
		next_s.logic_array = monitored;
		next_s.trig = rise;
		next_s.irq = (s.cfg[`CMP_ROUTE_MSB:`CMP_ROUTE_LSB] == `CMP_ROUTE_IRQ) &
			(|(flags & s.mask));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ============================================================
	// Outputs
	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign comparator_enable = s.cfg[`CMP_EN_BIT];
	assign positive_input_share = s.cfg[`CMP_EN_BIT];
	assign negative_input_select = s.cfg[`CMP_NEG_MSB:`CMP_NEG_LSB];
	assign response_time_select = s.cfg[`CMP_RESP_MSB:`CMP_RESP_LSB];
	assign hysteresis_enable = s.cfg[`CMP_HYST_BIT];
	assign comparator_output_pin = s.pin;
	assign programmable_logic_array = s.logic_array;
	assign adc_trigger = s.trig;
	assign irq = s.irq;

	// ============================================================
	// Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_enable_write;
		wr_ctrl && s.wstrb[1] |=> comparator_enable == $past(s.wdata[`CMP_EN_BIT]);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable not written");

	property p_neg_write;
		wr_ctrl && s.wstrb[1] |=>
			negative_input_select == $past(s.wdata[`CMP_NEG_MSB:`CMP_NEG_LSB]);
	endproperty
	a_neg_write: assert property (p_neg_write) else $error("input select not written");

	property p_resp_write;
		wr_ctrl && s.wstrb[0] |=>
			response_time_select == $past(s.wdata[`CMP_RESP_MSB:`CMP_RESP_LSB]) &&
			hysteresis_enable == $past(s.wdata[`CMP_HYST_BIT]);
	endproperty
	a_resp_write: assert property (p_resp_write) else $error("response not set");

	property p_pin_route;
		comparator_output_pin |->
			$past(s.cfg[`CMP_ROUTE_MSB:`CMP_ROUTE_LSB] == `CMP_ROUTE_PIN && monitored);
	endproperty
	a_pin_route: assert property (p_pin_route) else $error("pin driven off route");

	property p_irq_route;
		irq |-> $past(s.cfg[`CMP_ROUTE_MSB:`CMP_ROUTE_LSB] == `CMP_ROUTE_IRQ);
	endproperty
	a_irq_route: assert property (p_irq_route) else $error("irq raised off route");

	property p_irq_level;
		s.cfg[`CMP_ROUTE_MSB:`CMP_ROUTE_LSB] == `CMP_ROUTE_IRQ &&
			(|(flags & s.mask)) |=> irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq not raised");

	property p_polarity;
		comparator_enable && $stable(raw_sync) && $stable(s.cfg) |->
			programmable_logic_array == ($past(raw_sync) ^ $past(s.cfg[`CMP_POL_BIT]));
	endproperty
	a_polarity: assert property (p_polarity) else $error("polarity wrong");

	property p_rise_sets;
		rise |=> rising_edge_flag ##0 adc_trigger;
	endproperty
	a_rise_sets: assert property (p_rise_sets) else $error("rise not flagged");

	property p_fall_sets;
		fall |=> falling_edge_flag;
	endproperty
	a_fall_sets: assert property (p_fall_sets) else $error("fall not flagged");

	property p_rise_clear;
		clr_rise && !rise |=> !rising_edge_flag;
	endproperty
	a_rise_clear: assert property (p_rise_clear) else $error("rise flag not cleared");

	property p_fall_hold;
		falling_edge_flag && !clr_fall |=> falling_edge_flag;
	endproperty
	a_fall_hold: assert property (p_fall_hold) else $error("fall flag lost");

	property p_fall_clear;
		clr_fall && !fall |=> !falling_edge_flag;
	endproperty
	a_fall_clear: assert property (p_fall_clear) else $error("fall flag not cleared");

	property p_reserved_zero;
		s_axi_rvalid |-> s_axi_rdata[31:11] == 21'h000000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

	property p_disabled_quiet;
		!comparator_enable |-> !rise ##1 !adc_trigger;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) else $error("edge while off");

	property p_write_answer;
		s.aw_held && s.w_held && !s.bvalid |=> s_axi_bvalid;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("no write response");

	property p_read_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid [*1] ##0 !s_axi_arready;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("no read response");

	c_rise: cover property (rise ##1 rising_edge_flag);
	c_fall: cover property (fall ##1 falling_edge_flag);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_irq: cover property ($rose(irq));

endmodule : voltage_comparator_control
`default_nettype wire

// ---- dv/comparator_core_model.sv ----
// Behavioural model of the analog comparator core and its input multiplexers.
// Assumes the bench sets input voltages as integers in units of 0.1 mV.
`timescale 1ns/1ps
`default_nettype none

module comparator_core_model #(
	parameter int HALF_SUPPLY = 16500
) (
	input wire logic aclk,
	input wire logic comparator_enable,
	input wire logic positive_input_share,
	input wire logic [1:0] negative_input_select,
	input wire logic [1:0] response_time_select,
	input wire logic hysteresis_enable,
	input var int pos_in,
	input var int ain3_in,
	input var int dac_in,
	output logic comparator_raw
);
	int neg;
	int hy;
	logic [3:0] pipe = 4'h0;

	// ============================================================
	// Input selection
	always_comb begin
		case (negative_input_select)
			2'h0: neg = HALF_SUPPLY;
			2'h1: neg = ain3_in;
			2'h2: neg = dac_in;
			default: neg = ain3_in + 1;
		endcase
		hy = hysteresis_enable ? 75 : 0;
	end

	// ============================================================
	// Decision
	// An unpowered core wanders, so a design that ignores the enable is caught
	always @(posedge aclk) begin
		if (!(comparator_enable && positive_input_share))
			pipe <= {pipe[2:0], ~pipe[0]};
		else if (pos_in > neg + hy)
			pipe <= {pipe[2:0], 1'b1};
		else if (pos_in < neg - hy)
			pipe <= {pipe[2:0], 1'b0};
		else
			pipe <= {pipe[2:0], pipe[0]};
	end

	// Slow response setting lags three more clocks
	assign comparator_raw = (response_time_select == 2'h0) ? pipe[3] : pipe[0];
endmodule : comparator_core_model

`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the comparator control block.
// Assumes the analog core model and the shared configuration header.
`timescale 1ns/1ps
`default_nettype none
`include "comparator_cfg.svh"

module tb;
	import comparator_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
	axi_addr_t awaddr = '0, araddr = '0;
	axi_data_t wdata = '0, rdata, d;
	axi_strb_t wstrb = 4'hf;
	axi_resp_t bresp, rresp, r;
	logic awready, wready, bvalid, arready, rvalid, raw, en, share, hyst, pin, array_in, trig, irq;
	logic [1:0] nsel, rsel;
	int pos = 0, ain3 = 5000, dac = 18000;
	int fail_count = 0, samples_checked = 0, trig_count = 0;

	voltage_comparator_control u_voltage_comparator_control (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .comparator_raw(raw),
		.comparator_enable(en), .positive_input_share(share),
		.negative_input_select(nsel), .response_time_select(rsel),
		.hysteresis_enable(hyst), .comparator_output_pin(pin),
		.programmable_logic_array(array_in),
		.adc_trigger(trig), .irq(irq)
	);

	comparator_core_model u_comparator_core_model (
		.aclk(aclk), .comparator_enable(en), .positive_input_share(share),
		.negative_input_select(nsel), .response_time_select(rsel),
		.hysteresis_enable(hyst), .pos_in(pos), .ain3_in(ain3), .dac_in(dac),
		.comparator_raw(raw)
	);

	initial forever #20 aclk = ~aclk;

	always @(posedge aclk) if (trig === 1'b1) trig_count++;

	// ============================================================
	// Shared tasks
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask : cyc

	// Bready stays high from the start; the write ends at the response edge
	task automatic wr(input axi_addr_t a, input axi_data_t v, output axi_resp_t rs);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 40);
		if (!bvalid) fail_count++;
		rs = bresp;
	endtask : wr

	task automatic rd(input axi_addr_t a, output axi_data_t v, output axi_resp_t rs);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 40);
		if (!rvalid) fail_count++;
		v = rdata;
		rs = rresp;
	endtask : rd

	task automatic wc(input axi_addr_t a, input axi_data_t v);
		wr(a, v, r);
		check(32'(r), 32'(`AXI_RESP_OKAY));
	endtask : wc

	task automatic rdc(input axi_addr_t a, input axi_data_t m, input axi_data_t exp);
		rd(a, d, r);
		check(d & m, exp);
	endtask : rdc

	function automatic axi_data_t cw(input logic [1:0] ns, input logic [1:0] ro,
			input logic pl, input logic [1:0] rs, input logic hy);
		return {21'h0, 1'b1, ns, ro, pl, rs, hy, 2'h0};
	endfunction : cw

	// ============================================================
	// Scenarios
	task automatic t_reset();
		rdc(`CMP_CTRL_ADDR, 32'hffffffff, 32'h0);
		rdc(`CMP_MASK_ADDR, 32'hffffffff, 32'h0);
		check(32'({en, share, pin, irq}), 32'h0);
	endtask : t_reset

	task automatic t_fields();
		wc(`CMP_CTRL_ADDR, 32'hfffffffc);
		check(32'({en, share, nsel, rsel, hyst}), 32'h7f);
		rdc(`CMP_CTRL_ADDR, 32'hfffffffc, 32'h7fc);
		wc(`CMP_CTRL_ADDR, 32'h0);
		check(32'({en, share}), 32'h0);
		wstrb <= 4'h2;
		wc(`CMP_CTRL_ADDR, 32'hfffffffc);
		wstrb <= 4'hf;
		check(32'({en, share, nsel, rsel, hyst}), 32'h78);
		rdc(`CMP_CTRL_ADDR, 32'hfffffffc, 32'h700);
	endtask : t_fields

	task automatic t_negsel();
		logic [2:0] exp_v;
		exp_v = 3'b010;
		pos <= 10000;
		for (int i = 0; i < 3; i++) begin
			wc(`CMP_CTRL_ADDR, cw(i[1:0], 2'h2, 1'b0, 2'h3, 1'b0));
			cyc(10);
			rdc(`CMP_STAT_ADDR, 32'h1, 32'(exp_v[i]));
		end
	endtask : t_negsel

	task automatic t_edges();
		axi_data_t c;
		int t0;
		c = cw(2'h1, 2'h2, 1'b0, 2'h3, 1'b0);
		pos <= 4000;
		wc(`CMP_CTRL_ADDR, c);
		cyc(10);
		wc(`CMP_CTRL_ADDR, c | 32'h3);
		t0 = trig_count;
		pos <= 6000;
		cyc(10);
		check(32'({pin, array_in}), 32'h3);
		rdc(`CMP_STAT_ADDR, 32'h3, 32'h3);
		check(32'(trig_count - t0), 32'h1);
		rdc(`CMP_CTRL_ADDR, 32'h3, 32'h2);
		wc(`CMP_CTRL_ADDR, c);
		rdc(`CMP_CTRL_ADDR, 32'h3, 32'h2);
		pos <= 4000;
		cyc(10);
		check(32'({pin, array_in}), 32'h0);
		rdc(`CMP_STAT_ADDR, 32'h3, 32'h0);
		rdc(`CMP_CTRL_ADDR, 32'h3, 32'h3);
		wc(`CMP_CTRL_ADDR, c | 32'h1);
		rdc(`CMP_CTRL_ADDR, 32'h3, 32'h2);
		wc(`CMP_CTRL_ADDR, c | 32'h2);
		rdc(`CMP_CTRL_ADDR, 32'h3, 32'h0);
	endtask : t_edges

	// Slow response setting here, so the wait covers the model's longer lag
	task automatic t_polarity();
		wc(`CMP_CTRL_ADDR, cw(2'h1, 2'h2, 1'b1, 2'h0, 1'b0));
		cyc(10);
		check(32'(pin), 32'h1);
		pos <= 6000;
		cyc(10);
		check(32'(pin), 32'h0);
	endtask : t_polarity

	task automatic t_irq();
		axi_data_t c;
		c = cw(2'h1, 2'h3, 1'b0, 2'h3, 1'b0);
		pos <= 4000;
		wc(`CMP_CTRL_ADDR, c);
		cyc(10);
		wc(`CMP_CTRL_ADDR, c | 32'h3);
		wc(`CMP_MASK_ADDR, 32'h1);
		pos <= 6000;
		cyc(10);
		check(32'({irq, pin}), 32'h0);
		wc(`CMP_MASK_ADDR, 32'h2);
		cyc(2);
		check(32'(irq), 32'h1);
		wc(`CMP_CTRL_ADDR, c | 32'h2);
		cyc(2);
		check(32'(irq), 32'h0);
	endtask : t_irq

	task automatic t_hyst();
		axi_data_t c;
		c = cw(2'h1, 2'h2, 1'b0, 2'h3, 1'b1);
		pos <= 4000;
		wc(`CMP_CTRL_ADDR, c);
		cyc(10);
		pos <= 5050;
		cyc(10);
		rdc(`CMP_STAT_ADDR, 32'h1, 32'h0);
		wc(`CMP_CTRL_ADDR, c & ~32'h4);
		cyc(10);
		rdc(`CMP_STAT_ADDR, 32'h1, 32'h1);
	endtask : t_hyst

	task automatic t_unmapped();
		wc(`CMP_STAT_ADDR, 32'h3);
		wr(32'hffff0500, 32'h5, r);
		check(32'(r), 32'(`AXI_RESP_SLVERR));
		rd(32'hffff0500, d, r);
		check(d, 32'h0);
		check(32'(r), 32'(`AXI_RESP_SLVERR));
	endtask : t_unmapped

	// ============================================================
	// Main sequence
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_fields();
		t_negsel();
		t_edges();
		t_polarity();
		t_irq();
		t_hyst();
		t_unmapped();
		complete_run();
	end

	initial begin
		#400000;
		fail_count++;
		complete_run();
	end
endmodule : tb

`default_nettype wire
